// ===== spi_status_flags.sv
// Notes on behaviour
// - Status register reads anytime; writes to it change nothing.
// - Receive-full, status bit 7, sets when received data reaches data register.
// - Status bit 5 reads 1 while transmit data register is empty.
// - Mode-fault, bit 4, sets on low select as master with detection on.
// - Mode-fault clears on status read seeing it, then first control 1 write.
// - Byte mode: receive-full clears on qualified status read then low byte read.
// - Word mode: lone low byte read after qualified read clears; high byte lost.
// - High byte reads never touch receive-full.
// - Word mode: qualified word read of both bytes clears receive-full.
// - Data writes ignored while not empty; low write after qualified read clears.
module spi_status_flags
   import spi_status_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   // Serial link
   input wire logic ss_n,
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   // Interrupt
   output logic irq
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0] ss_sync;
      logic [2:0] sck_sync;
      logic [1:0] mosi_sync;
      logic enable;
      logic master;
      logic wide;
      logic fault_detect_enable;
      logic [15:0] tx_data;
      logic [15:0] shift_tx;
      logic [15:0] shift_rx;
      logic [15:0] rx_data;
      logic [4:0] bit_count;
      logic hold_shift;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_enable;
      logic [DATA_W-1:0] rdata;
      logic irq;
      logic miso;
      logic miso_oe;
   } top_state_t;

   top_state_t s;
   top_state_t next_s;

   logic receive_full_flag;
   logic transmit_empty_flag;
   logic mode_fault_flag;
   logic rx_armed;
   logic tx_armed;
   logic mf_armed;

   logic status_rd;
   logic high_rd;
   logic low_rd;
   logic word_rd;
   logic ctrl1_wr;
   logic high_wr;
   logic low_wr;
   logic word_wr;
   logic ss_low;
   logic ss_fall;
   logic sck_rise;
   logic sck_fall;
   logic slave_active;
   logic rx_done;
   logic rx_set;
   logic tx_move;
   logic mf_set;
   logic rx_clear;
   logic tx_clear;
   logic [15:0] rx_next;
   logic [4:0] last_bit;
   logic [7:0] status_value;
   logic [IRQ_W-1:0] events;

   // ---------------------------------------------------------------
   // Register decode
   // ---------------------------------------------------------------
   always_comb begin
      status_rd = rd && (addr == OFF_STATUS);
      high_rd = rd && (addr == OFF_DATA_HIGH);
      low_rd = rd && (addr == OFF_DATA_LOW);
      word_rd = rd && (addr == OFF_DATA_WORD);
      ctrl1_wr = wr && (addr == OFF_CTRL1);
      high_wr = wr && (addr == OFF_DATA_HIGH);
      low_wr = wr && (addr == OFF_DATA_LOW);
      word_wr = wr && (addr == OFF_DATA_WORD);
   end

   // ---------------------------------------------------------------
   // Link sampling
   // ---------------------------------------------------------------
   // Only the second sync stage and its delayed copy are examined,
   // so the first stage never feeds logic directly.
   always_comb begin
      ss_low = !s.ss_sync[1];
      ss_fall = s.ss_sync[2] && !s.ss_sync[1];
      sck_rise = s.sck_sync[1] && !s.sck_sync[2];
      sck_fall = !s.sck_sync[1] && s.sck_sync[2];
      slave_active = s.enable && !s.master && ss_low;
      last_bit = s.wide ? LAST_BIT_WORD : LAST_BIT_BYTE;
   end

   // ---------------------------------------------------------------
   // Flag events
   // ---------------------------------------------------------------
   always_comb begin
      rx_next = {s.shift_rx[14:0], s.mosi_sync[1]};
      rx_done = slave_active && sck_rise && (s.bit_count == last_bit);
      // Receive completes only into an empty data register
      rx_set = rx_done && !receive_full_flag;
      // Queued data leaves for the shifter
      tx_move = !transmit_empty_flag && s.enable && !s.master &&
                (ss_fall || rx_done);
      // Low select while master with detection on
      mf_set = ss_low && s.master && s.fault_detect_enable;
      // Low byte or word read clears
      rx_clear = low_rd || word_rd;
      // Only the low byte or word write can empty-clear
      tx_clear = (low_wr || word_wr) && transmit_empty_flag;
      status_value = 8'h00;
      status_value[STATUS_RX_FULL_BIT] = receive_full_flag;
      status_value[STATUS_TX_EMPTY_BIT] = transmit_empty_flag;
      status_value[STATUS_MODE_FAULT_BIT] = mode_fault_flag;
      events = '0;
      events[IRQ_RX_FULL_BIT] = rx_set;
      events[IRQ_TX_EMPTY_BIT] = tx_move;
      events[IRQ_MODE_FAULT_BIT] = mf_set && !mode_fault_flag;
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.ss_sync = {s.ss_sync[1:0], ss_n};
      next_s.sck_sync = {s.sck_sync[1:0], sck};
      next_s.mosi_sync = {s.mosi_sync[0], mosi};

      // Status offset has no write branch
      if (ctrl1_wr) begin
         next_s.enable = wdata[CTRL1_ENABLE_BIT];
         next_s.master = wdata[CTRL1_MASTER_BIT];
      end
      if (wr && (addr == OFF_CTRL2)) begin
         next_s.wide = wdata[CTRL2_WIDE_BIT];
         next_s.fault_detect_enable = wdata[CTRL2_FAULT_DETECT_BIT];
      end

      // Writes dropped while data still queued
      if (transmit_empty_flag) begin
         if (high_wr) begin
            next_s.tx_data[15:8] = wdata[7:0];
         end
         if (low_wr) begin
            next_s.tx_data[7:0] = wdata[7:0];
         end
         if (word_wr) begin
            next_s.tx_data = wdata;
         end
      end

      // Frame start restarts the bit count
      if (ss_fall) begin
         next_s.bit_count = 5'h00;
      end else if (slave_active && sck_rise) begin
         next_s.shift_rx = rx_next;
         if (rx_done) begin
            next_s.bit_count = 5'h00;
         end else begin
            next_s.bit_count = s.bit_count + 5'h01;
         end
      end

      // Received word lands in the data register
      if (rx_set) begin
         next_s.rx_data = s.wide ? rx_next : {8'h00, rx_next[7:0]};
      end

      // A mid-frame reload must survive the very next falling edge
      if (tx_move) begin
         next_s.shift_tx = s.tx_data;
         next_s.hold_shift = rx_done;
      end else if (slave_active && sck_fall) begin
         if (s.hold_shift) begin
            next_s.hold_shift = 1'b0;
         end else begin
            next_s.shift_tx = {s.shift_tx[14:0], 1'b0};
         end
      end

      // Sticky interrupt status, set beats clear
      if (wr && (addr == OFF_IRQ_CLEAR)) begin
         next_s.irq_status = s.irq_status & ~wdata[IRQ_W-1:0];
      end
      next_s.irq_status = next_s.irq_status | events;
      if (wr && (addr == OFF_IRQ_ENABLE)) begin
         next_s.irq_enable = wdata[IRQ_W-1:0];
      end
      next_s.irq = |(next_s.irq_status & next_s.irq_enable);

      // Read data stand for one cycle only
      next_s.rdata = '0;
      if (rd) begin
         case (addr)
            OFF_STATUS: next_s.rdata = {8'h00, status_value};
            OFF_CTRL1: begin
               next_s.rdata[CTRL1_ENABLE_BIT] = s.enable;
               next_s.rdata[CTRL1_MASTER_BIT] = s.master;
            end
            OFF_CTRL2: begin
               next_s.rdata[CTRL2_WIDE_BIT] = s.wide;
               next_s.rdata[CTRL2_FAULT_DETECT_BIT] = s.fault_detect_enable;
            end
            OFF_DATA_HIGH: next_s.rdata = {8'h00, s.rx_data[15:8]};
            OFF_DATA_LOW: next_s.rdata = {8'h00, s.rx_data[7:0]};
            OFF_DATA_WORD: next_s.rdata = s.rx_data;
            OFF_IRQ_STATUS: next_s.rdata = {13'h0000, s.irq_status};
            OFF_IRQ_ENABLE: next_s.rdata = {13'h0000, s.irq_enable};
            default: next_s.rdata = '0;
         endcase
      end

      next_s.miso = s.wide ? next_s.shift_tx[15] : next_s.shift_tx[7];
      next_s.miso_oe = slave_active;
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
         s.ss_sync <= 3'h7;
         s.enable <= CTRL_RESET[CTRL1_ENABLE_BIT];
         s.master <= CTRL_RESET[CTRL1_MASTER_BIT];
         s.wide <= CTRL_RESET[CTRL2_WIDE_BIT];
         s.fault_detect_enable <= CTRL_RESET[CTRL2_FAULT_DETECT_BIT];
         s.irq_status <= IRQ_RESET;
         s.irq_enable <= IRQ_RESET;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // Flags
   // ---------------------------------------------------------------
   // High byte reads are not a clear access
   flag_cell #(
      .RESET_VALUE(RX_FULL_RESET)
   ) rx_full_cell (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .set(rx_set),
      .status_read(status_rd),
      .clear_access(rx_clear),
      .other_clear(!s.enable),
      .flag(receive_full_flag),
      .armed(rx_armed)
   );

   flag_cell #(
      .RESET_VALUE(TX_EMPTY_RESET)
   ) tx_empty_cell (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .set(tx_move),
      .status_read(status_rd),
      .clear_access(tx_clear),
      .other_clear(1'b0),
      .flag(transmit_empty_flag),
      .armed(tx_armed)
   );

   // First control 1 write is the clear access
   flag_cell #(
      .RESET_VALUE(MODE_FAULT_RESET)
   ) mode_fault_cell (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .set(mf_set),
      .status_read(status_rd),
      .clear_access(ctrl1_wr),
      .other_clear(1'b0),
      .flag(mode_fault_flag),
      .armed(mf_armed)
   );

   assign rdata = s.rdata;
   assign miso = s.miso;
   assign miso_oe = s.miso_oe;
   assign irq = s.irq;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   status_read_value_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      clk_en && status_rd
      |=> rdata[7:0] == {$past(receive_full_flag), 1'b0,
                         $past(transmit_empty_flag),
                         $past(mode_fault_flag), 4'h0})
      else $error("status read returned wrong flags");

   status_write_inert_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      clk_en && wr && (addr == OFF_STATUS) && !rx_set && s.enable
      |=> receive_full_flag == $past(receive_full_flag))
      else $error("status write changed receive flag");

   rx_full_set_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      clk_en && rx_set |=> receive_full_flag && (s.rx_data[7:0] ==
         $past(rx_next[7:0])))
      else $error("receive flag or data missing after frame");

   tx_empty_set_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      clk_en && tx_move |=> transmit_empty_flag && s.shift_tx ==
         $past(s.tx_data))
      else $error("transmit register not emptied into shifter");

   mode_fault_set_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      clk_en && ss_low && s.master && s.fault_detect_enable
      |=> mode_fault_flag)
      else $error("mode fault not raised");

   mode_fault_clear_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      clk_en && mf_armed && mode_fault_flag && ctrl1_wr && !mf_set
      |=> !mode_fault_flag)
      else $error("mode fault not cleared by read then control write");

   rx_full_clear_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      clk_en && rx_armed && rx_clear && !rx_set |=> !receive_full_flag)
      else $error("receive flag not cleared by qualified data read");

   high_read_inert_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      clk_en && high_rd && receive_full_flag && s.enable
      |=> receive_full_flag)
      else $error("high byte read cleared receive flag");

   tx_write_ignored_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      clk_en && !transmit_empty_flag && (high_wr || low_wr || word_wr)
      |=> s.tx_data == $past(s.tx_data))
      else $error("data write accepted while not empty");

   tx_empty_clear_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      clk_en && tx_armed && (low_wr || word_wr) && !tx_move
      |=> !transmit_empty_flag)
      else $error("empty flag not cleared by qualified low write");

endmodule

// ===== spi_status_pkg.sv
package spi_status_pkg;

   // ---------------------------------------------------------------
   // Register bus geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] OFF_STATUS = 4'h0;
   localparam logic [3:0] OFF_CTRL1 = 4'h1;
   localparam logic [3:0] OFF_CTRL2 = 4'h2;
   localparam logic [3:0] OFF_DATA_HIGH = 4'h4;
   localparam logic [3:0] OFF_DATA_LOW = 4'h5;
   localparam logic [3:0] OFF_DATA_WORD = 4'h6;
   localparam logic [3:0] OFF_IRQ_STATUS = 4'h8;
   localparam logic [3:0] OFF_IRQ_CLEAR = 4'h9;
   localparam logic [3:0] OFF_IRQ_ENABLE = 4'hA;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int STATUS_RX_FULL_BIT = 7;
   localparam int STATUS_TX_EMPTY_BIT = 5;
   localparam int STATUS_MODE_FAULT_BIT = 4;
   localparam int CTRL1_ENABLE_BIT = 6;
   localparam int CTRL1_MASTER_BIT = 4;
   localparam int CTRL2_WIDE_BIT = 6;
   localparam int CTRL2_FAULT_DETECT_BIT = 4;
   localparam int IRQ_RX_FULL_BIT = 0;
   localparam int IRQ_TX_EMPTY_BIT = 1;
   localparam int IRQ_MODE_FAULT_BIT = 2;
   localparam int IRQ_W = 3;

   // ---------------------------------------------------------------
   // Reset values and counts
   // ---------------------------------------------------------------
   localparam logic RX_FULL_RESET = 1'b0;
   localparam logic TX_EMPTY_RESET = 1'b1;
   localparam logic MODE_FAULT_RESET = 1'b0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [2:0] IRQ_RESET = 3'h0;
   localparam logic [4:0] LAST_BIT_BYTE = 5'h07;
   localparam logic [4:0] LAST_BIT_WORD = 5'h0F;

endpackage

// ===== flag_cell.sv
module flag_cell
   import spi_status_pkg::*;
#(
   parameter logic RESET_VALUE = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Events
   input wire logic set,
   input wire logic status_read,
   input wire logic clear_access,
   input wire logic other_clear,
   // State
   output logic flag,
   output logic armed
);

   typedef struct packed {
      logic flag;
      logic armed;
   } cell_state_t;

   cell_state_t s;
   cell_state_t next_s;
   logic clear_fire;

   always_comb begin
      next_s = s;
      clear_fire = (clear_access && s.armed) || other_clear;
      if (clear_fire) begin
         next_s.armed = 1'b0;
      end else if (status_read && s.flag) begin
         next_s.armed = 1'b1;
      end
      // Set beats a clear arriving in the same cycle
      if (set) begin
         next_s.flag = 1'b1;
      end else if (clear_fire) begin
         next_s.flag = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '{flag: RESET_VALUE, armed: 1'b0};
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   assign flag = s.flag;
   assign armed = s.armed;

   no_arm_clear_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      clk_en && flag && !armed && clear_access && !other_clear
      |=> flag)
      else $error("flag cleared without a qualifying status read");

   arm_needs_flag_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      !flag |-> !armed)
      else $error("qualification held while flag is clear");

endmodule

// ===== spi_master_model.sv
module spi_master_model (
   // Serial link
   output logic ss_n,
   output logic sck,
   output logic mosi,
   input wire logic miso
);
   timeunit 1ns;
   timeprecision 100ps;

   localparam real HALF = 62.5;

   initial begin
      ss_n = 1'b1;
      sck = 1'b0;
      mosi = 1'b1;
   end

   // -------------------------------------------------------------
   // Frames
   // -------------------------------------------------------------
   // Frame delivers one byte or word
   task automatic frame(input logic [15:0] tx, input int nbits,
                        output logic [15:0] rx);
      rx = 16'h0000;
      ss_n <= 1'b0;
      #(HALF * 2);
      for (int i = nbits - 1; i >= 0; i--) begin
         mosi <= tx[i];
         #HALF sck = 1'b1;
         rx = {rx[14:0], miso};
         #HALF sck = 1'b0;
      end
      #HALF ss_n = 1'b1;
      // Released line must not keep the last bit
      mosi = ~mosi;
   endtask

   // Select only, no clock, for fault tests
   task automatic select(input logic level);
      ss_n <= level;
   endtask
endmodule

// ===== spi_status_flags_bench.sv
module spi_status_flags_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import spi_status_pkg::*;

   logic clk, reset_n, clk_en, wr, rd;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic ss_n, sck, mosi, miso, miso_oe, irq;
   logic [15:0] v, rx;
   int miscompares, n_compared;

   spi_status_flags uut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .ss_n(ss_n), .sck(sck), .mosi(mosi), .miso(miso),
      .miso_oe(miso_oe), .irq(irq));

   spi_master_model m (.ss_n(ss_n), .sck(sck), .mosi(mosi), .miso(miso));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // -------------------------------------------------------------
   // Access tasks
   // -------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data only stands in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd_reg(a, d);
      check(d, exp);
   endtask

   task automatic fault_pulse;
      m.select(1'b0);
      repeat (8) @(posedge clk);
      m.select(1'b1);
      repeat (8) @(posedge clk);
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Whole run is about eleven microseconds
   initial begin
      #200000;
      miscompares++;
      print_verdict();
   end

   // -------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      clk_en = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      miscompares = 0;
      n_compared = 0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      rd_chk(OFF_STATUS, 16'h0020);
      wr_reg(OFF_STATUS, 16'h00FF);
      rd_chk(OFF_STATUS, 16'h0020);
      rd_chk(4'h3, 16'h0000);
      // Frozen clock enable drops the write
      @(posedge clk) clk_en <= 1'b0;
      wr_reg(OFF_IRQ_ENABLE, 16'h0007);
      @(posedge clk) clk_en <= 1'b1;
      rd_chk(OFF_IRQ_ENABLE, 16'h0000);
      wr_reg(OFF_IRQ_ENABLE, 16'h0001);
      // Byte mode slave
      wr_reg(OFF_CTRL1, 16'h0040);
      wr_reg(OFF_CTRL2, 16'h0000);
      rd_chk(OFF_STATUS, 16'h0020);
      wr_reg(OFF_DATA_LOW, 16'h00A5);
      rd_chk(OFF_STATUS, 16'h0000);
      wr_reg(OFF_DATA_LOW, 16'h003C);
      m.frame(16'h005A, 8, rx);
      check(rx, 16'h00A5);
      check({15'h0000, irq}, 16'h0001);
      // Low read before any qualifying status read
      rd_reg(OFF_DATA_LOW, v);
      rd_chk(OFF_STATUS, 16'h00A0);
      // Status write while enabled must leave the flags alone
      wr_reg(OFF_STATUS, 16'h0000);
      for (int i = 0; i < 2; i++)
         rd_chk(OFF_DATA_HIGH, 16'h0000);
      rd_chk(OFF_STATUS, 16'h00A0);
      rd_chk(OFF_DATA_LOW, 16'h005A);
      rd_chk(OFF_STATUS, 16'h0020);
      rd_chk(OFF_IRQ_STATUS, 16'h0003);
      check({15'h0000, irq}, 16'h0001);
      wr_reg(OFF_IRQ_CLEAR, 16'h0007);
      rd_chk(OFF_IRQ_STATUS, 16'h0000);
      check({15'h0000, irq}, 16'h0000);
      wr_reg(OFF_IRQ_ENABLE, 16'h0000);
      // Word mode
      wr_reg(OFF_CTRL2, 16'h0040);
      rd_reg(OFF_STATUS, v);
      wr_reg(OFF_DATA_WORD, 16'h1234);
      m.frame(16'hBEEF, 16, rx);
      check(rx, 16'h1234);
      check({15'h0000, irq}, 16'h0000);
      rd_chk(OFF_STATUS, 16'h00A0);
      rd_chk(OFF_DATA_WORD, 16'hBEEF);
      rd_chk(OFF_STATUS, 16'h0020);
      m.frame(16'hC0DE, 16, rx);
      rd_chk(OFF_STATUS, 16'h00A0);
      rd_chk(OFF_DATA_LOW, 16'h00DE);
      rd_chk(OFF_STATUS, 16'h0020);
      // Qualification lost when disable clears the flag
      m.frame(16'h0F0F, 16, rx);
      rd_chk(OFF_STATUS, 16'h00A0);
      wr_reg(OFF_CTRL1, 16'h0000);
      wr_reg(OFF_CTRL1, 16'h0040);
      m.frame(16'h7171, 16, rx);
      rd_chk(OFF_DATA_LOW, 16'h0071);
      rd_chk(OFF_STATUS, 16'h00A0);
      // Output enable follows select as an enabled slave
      m.select(1'b0);
      repeat (8) @(posedge clk);
      #1 check({15'h0000, miso_oe}, 16'h0001);
      m.select(1'b1);
      repeat (8) @(posedge clk);
      #1 check({15'h0000, miso_oe}, 16'h0000);
      // Mode fault as master
      wr_reg(OFF_CTRL1, 16'h0050);
      wr_reg(OFF_CTRL2, 16'h0000);
      fault_pulse();
      rd_reg(OFF_STATUS, v);
      check(v & 16'h0010, 16'h0000);
      wr_reg(OFF_CTRL2, 16'h0010);
      fault_pulse();
      wr_reg(OFF_CTRL1, 16'h0050);
      rd_reg(OFF_STATUS, v);
      check(v & 16'h0010, 16'h0010);
      wr_reg(OFF_CTRL1, 16'h0050);
      rd_reg(OFF_STATUS, v);
      check(v & 16'h0010, 16'h0000);
      print_verdict();
   end
endmodule
